/* rtl/pwm_sync_pkg.sv */
`default_nettype none
package pwm_sync_pkg;
  // register indexes; byte address is four times the index
  localparam logic [7:0] idx_timebase_control = 8'h00;
  localparam logic [7:0] idx_timebase_status = 8'h01;
  localparam logic [7:0] idx_phase_value = 8'h03;
  localparam logic [7:0] idx_timebase_count = 8'h04;
  localparam logic [7:0] idx_period_value = 8'h05;
  localparam logic [7:0] idx_compare_control = 8'h07;
  localparam logic [7:0] idx_compare_a_fine_extension = 8'h08;
  localparam logic [7:0] idx_compare_a_value = 8'h09;
  localparam logic [7:0] idx_compare_b_value = 8'h0a;
  localparam logic [7:0] idx_sync_source = 8'h20;
  localparam logic [7:0] idx_compare_a_fine_mirror = 8'h2c;
  localparam logic [7:0] idx_compare_a_mirror = 8'h2d;
  // timebase_control fields
  localparam int tbc_mode_lo = 0;
  localparam int tbc_phase_en = 2;
  localparam int tbc_period_imm = 3;
  localparam int tbc_sync_out_lo = 4;
  localparam int tbc_soft_sync = 6;
  localparam int tbc_div_lo = 7;
  localparam int tbc_div_w = 6;
  localparam int tbc_dir_sel = 13;
  // compare_control fields
  localparam int cc_a_point_lo = 0;
  localparam int cc_b_point_lo = 2;
  localparam int cc_a_shadow_off = 4;
  localparam int cc_b_shadow_off = 6;
  localparam int cc_a_full = 8;
  localparam int cc_b_full = 9;
  // sync source fields
  localparam int ss_dca_en = 0;
  localparam int ss_dcb_en = 1;
  // reset values
  localparam logic [15:0] timebase_control_rst = 16'h0083;
  localparam logic [15:0] compare_control_rst = 16'h0000;
  localparam logic [15:0] period_rst = 16'h0000;
  // address bit span used for decode
  localparam int addr_w = 10;

  typedef enum logic [1:0]
  {
    mode_up = 2'b00,
    mode_down = 2'b01,
    mode_updown = 2'b10,
    mode_frozen = 2'b11
  } count_mode_t;

  typedef enum logic [1:0]
  {
    so_sync_in = 2'b00,
    so_zero = 2'b01,
    so_cmp_b = 2'b10,
    so_off = 2'b11
  } sync_out_sel_t;

  typedef enum logic [1:0]
  {
    lp_zero = 2'b00,
    lp_period = 2'b01,
    lp_both = 2'b10,
    lp_none = 2'b11
  } load_point_t;

  typedef struct packed
  {
    logic cmp_a;
    logic cmp_b;
    logic zero;
    logic period;
  } events_t;
endpackage
`default_nettype wire

/* rtl/pwm_timebase_sync_and_compare.sv */
`timescale 1ns/10ps
`default_nettype none
module pwm_timebase_sync_and_compare
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // sync chain and global controls
  input wire logic sync_in_pulse,
  input wire logic global_tick_align,
  input wire logic digital_compare_a_event_one,
  input wire logic digital_compare_b_event_one,
  output logic sync_out_pulse,
  // counter and compare events
  output logic [15:0] timebase_count,
  output logic count_up,
  output pwm_sync_pkg::events_t events
);

  // ==========================================================
  // input synchronisers
  logic sync_in_m_q;
  logic sync_in_s_q;
  logic align_m_q;
  logic align_s_q;
  logic dca_m_q;
  logic dca_s_q;
  logic dcb_m_q;
  logic dcb_s_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sync_in_m_q <= 1'b0;
      sync_in_s_q <= 1'b0;
      align_m_q <= 1'b0;
      align_s_q <= 1'b0;
      dca_m_q <= 1'b0;
      dca_s_q <= 1'b0;
      dcb_m_q <= 1'b0;
      dcb_s_q <= 1'b0;
    end
    else
    begin
      sync_in_m_q <= sync_in_pulse;
      sync_in_s_q <= sync_in_m_q;
      align_m_q <= global_tick_align;
      align_s_q <= align_m_q;
      dca_m_q <= digital_compare_a_event_one;
      dca_s_q <= dca_m_q;
      dcb_m_q <= digital_compare_b_event_one;
      dcb_s_q <= dcb_m_q;
    end
  end

  // ==========================================================
  // registers
  logic [15:0] tb_ctl_q;
  logic [15:0] phase_q;
  logic [15:0] prd_shadow_q;
  logic [15:0] prd_active_q;
  logic [15:0] cmp_ctl_q;
  logic [15:0] compare_a_shadow_q;
  logic [15:0] compare_a_active_q;
  logic [15:0] compare_b_shadow_q;
  logic [15:0] compare_b_active_q;
  logic [15:0] compare_a_fine_q;
  logic [1:0] sync_src_q;
  logic soft_sync_q;
  logic compare_a_full_q;
  logic compare_b_full_q;
  logic wait_q;

  logic [7:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic [15:0] wdata;
  logic [15:0] wmask;
  logic [15:0] cnt_q;
  logic dir_up_q;
  logic tick;
  logic load_a;
  logic load_b;
  logic ctr_zero;
  logic ctr_prd;

  assign idx = address[9:2];
  assign wr_acc = write && !wait_q;
  assign rd_acc = read && !wait_q;
  assign wmask = {{8{byteenable[1]}}, {8{byteenable[0]}}};
  assign wdata = writedata[15:0];

  // one wait state per access: request accepted in its second cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      wait_q <= 1'b1;
    else if ((read || write) && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [15:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tb_ctl_q <= pwm_sync_pkg::timebase_control_rst;
      phase_q <= 16'h0000;
      cmp_ctl_q <= pwm_sync_pkg::compare_control_rst;
      compare_a_fine_q <= 16'h0000;
      sync_src_q <= 2'h0;
    end
    else if (wr_acc)
    begin
      unique case (idx)
        pwm_sync_pkg::idx_timebase_control:
          tb_ctl_q <= merge(tb_ctl_q, wdata, wmask)
                      & ~(16'h0001 << pwm_sync_pkg::tbc_soft_sync);
        pwm_sync_pkg::idx_phase_value:
          phase_q <= merge(phase_q, wdata, wmask);
        pwm_sync_pkg::idx_compare_control:
          cmp_ctl_q <= merge(cmp_ctl_q, wdata, wmask);
        pwm_sync_pkg::idx_compare_a_fine_extension,
        pwm_sync_pkg::idx_compare_a_fine_mirror:
          compare_a_fine_q <= merge(compare_a_fine_q, wdata, wmask);
        pwm_sync_pkg::idx_sync_source:
          sync_src_q <= byteenable[0] ? wdata[1:0] : sync_src_q;
        default:
          ;
      endcase
    end
  end

  // write-one pulse, reads back zero
  always_ff @(posedge clock)
  begin
    if (rst)
      soft_sync_q <= 1'b0;
    else
      soft_sync_q <= wr_acc && byteenable[0]
                     && idx == pwm_sync_pkg::idx_timebase_control
                     && wdata[pwm_sync_pkg::tbc_soft_sync];
  end

  // ==========================================================
  // shadowed period
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prd_shadow_q <= pwm_sync_pkg::period_rst;
      prd_active_q <= pwm_sync_pkg::period_rst;
    end
    else
    begin
      if (wr_acc && idx == pwm_sync_pkg::idx_period_value)
      begin
        if (tb_ctl_q[pwm_sync_pkg::tbc_period_imm])
          prd_active_q <= merge(prd_active_q, wdata, wmask);
        else
          prd_shadow_q <= merge(prd_shadow_q, wdata, wmask);
      end
      else if (!tb_ctl_q[pwm_sync_pkg::tbc_period_imm] && tick
               && ctr_zero)
        prd_active_q <= prd_shadow_q;
    end
  end

  // ==========================================================
  // compare shadows
  function automatic logic load_due(input logic [1:0] pt,
                                    input logic z,
                                    input logic p);
    unique case (pwm_sync_pkg::load_point_t'(pt))
      pwm_sync_pkg::lp_zero: load_due = z;
      pwm_sync_pkg::lp_period: load_due = p;
      pwm_sync_pkg::lp_both: load_due = z || p;
      pwm_sync_pkg::lp_none: load_due = 1'b0;
    endcase
  endfunction

  logic wr_a;
  logic wr_b;
  assign wr_a = wr_acc && (idx == pwm_sync_pkg::idx_compare_a_value
                || idx == pwm_sync_pkg::idx_compare_a_mirror);
  assign wr_b = wr_acc && idx == pwm_sync_pkg::idx_compare_b_value;
  assign load_a = !cmp_ctl_q[pwm_sync_pkg::cc_a_shadow_off] && tick
    && load_due(cmp_ctl_q[pwm_sync_pkg::cc_a_point_lo +: 2],
                ctr_zero, ctr_prd);
  assign load_b = !cmp_ctl_q[pwm_sync_pkg::cc_b_shadow_off] && tick
    && load_due(cmp_ctl_q[pwm_sync_pkg::cc_b_point_lo +: 2],
                ctr_zero, ctr_prd);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      compare_a_shadow_q <= 16'h0000;
      compare_a_active_q <= 16'h0000;
      compare_a_full_q <= 1'b0;
    end
    else
    begin
      if (wr_a && cmp_ctl_q[pwm_sync_pkg::cc_a_shadow_off])
        compare_a_active_q <= merge(compare_a_active_q, wdata, wmask);
      else if (load_a)
        compare_a_active_q <= compare_a_shadow_q;
      if (wr_a && !cmp_ctl_q[pwm_sync_pkg::cc_a_shadow_off])
        compare_a_shadow_q <= merge(compare_a_shadow_q, wdata, wmask);
      // shadow-full flag: write sets, transfer clears, set wins
      if (wr_a && !cmp_ctl_q[pwm_sync_pkg::cc_a_shadow_off])
        compare_a_full_q <= 1'b1;
      else if (load_a)
        compare_a_full_q <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      compare_b_shadow_q <= 16'h0000;
      compare_b_active_q <= 16'h0000;
      compare_b_full_q <= 1'b0;
    end
    else
    begin
      if (wr_b && cmp_ctl_q[pwm_sync_pkg::cc_b_shadow_off])
        compare_b_active_q <= merge(compare_b_active_q, wdata, wmask);
      else if (load_b)
        compare_b_active_q <= compare_b_shadow_q;
      if (wr_b && !cmp_ctl_q[pwm_sync_pkg::cc_b_shadow_off])
        compare_b_shadow_q <= merge(compare_b_shadow_q, wdata, wmask);
      if (wr_b && !cmp_ctl_q[pwm_sync_pkg::cc_b_shadow_off])
        compare_b_full_q <= 1'b1;
      else if (load_b)
        compare_b_full_q <= 1'b0;
    end
  end

  // ==========================================================
  // time-base tick divider, gated by global align
  logic [5:0] div_q;
  logic tick_q;
  assign tick = tick_q;

  always_ff @(posedge clock)
  begin
    if (rst || !align_s_q)
    begin
      div_q <= 6'h00;
      tick_q <= 1'b0;
    end
    else if (div_q == tb_ctl_q[pwm_sync_pkg::tbc_div_lo +: 6])
    begin
      div_q <= 6'h00;
      tick_q <= 1'b1;
    end
    else
    begin
      div_q <= div_q + 6'h01;
      tick_q <= 1'b0;
    end
  end

  // ==========================================================
  // sync strobe: sources merged, held until the next tick
  logic sync_strobe;
  logic sync_pend_q;
  assign sync_strobe = sync_in_s_q || soft_sync_q
    || (sync_src_q[pwm_sync_pkg::ss_dca_en] && dca_s_q)
    || (sync_src_q[pwm_sync_pkg::ss_dcb_en] && dcb_s_q);

  always_ff @(posedge clock)
  begin
    if (rst)
      sync_pend_q <= 1'b0;
    else if (tick)
      sync_pend_q <= 1'b0;
    else if (sync_strobe)
      sync_pend_q <= 1'b1;
  end

  logic sync_now;
  assign sync_now = tick && (sync_pend_q || sync_strobe);

  // ==========================================================
  // counter
  pwm_sync_pkg::count_mode_t mode;
  assign mode = pwm_sync_pkg::count_mode_t'(
    tb_ctl_q[pwm_sync_pkg::tbc_mode_lo +: 2]);
  assign ctr_zero = cnt_q == 16'h0000;
  assign ctr_prd = cnt_q == prd_active_q;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      cnt_q <= 16'h0000;
      dir_up_q <= 1'b1;
    end
    else if (wr_acc && idx == pwm_sync_pkg::idx_timebase_count)
      cnt_q <= merge(cnt_q, wdata, wmask);
    else if (sync_now && tb_ctl_q[pwm_sync_pkg::tbc_phase_en]
             && mode != pwm_sync_pkg::mode_frozen)
    begin
      cnt_q <= phase_q;
      if (mode == pwm_sync_pkg::mode_updown)
        dir_up_q <= tb_ctl_q[pwm_sync_pkg::tbc_dir_sel];
      else
        dir_up_q <= mode == pwm_sync_pkg::mode_up;
    end
    else if (tick)
    begin
      unique case (mode)
        pwm_sync_pkg::mode_up:
        begin
          dir_up_q <= 1'b1;
          cnt_q <= ctr_prd ? 16'h0000 : cnt_q + 16'h0001;
        end
        pwm_sync_pkg::mode_down:
        begin
          dir_up_q <= 1'b0;
          cnt_q <= ctr_zero ? prd_active_q : cnt_q - 16'h0001;
        end
        pwm_sync_pkg::mode_updown:
        begin
          if (dir_up_q && (ctr_prd || cnt_q > prd_active_q))
          begin
            dir_up_q <= 1'b0;
            cnt_q <= cnt_q - 16'h0001;
          end
          else if (!dir_up_q && ctr_zero)
          begin
            dir_up_q <= 1'b1;
            cnt_q <= cnt_q + 16'h0001;
          end
          else if (dir_up_q)
            cnt_q <= cnt_q + 16'h0001;
          else
            cnt_q <= cnt_q - 16'h0001;
        end
        pwm_sync_pkg::mode_frozen:
          cnt_q <= cnt_q;
      endcase
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      timebase_count <= 16'h0000;
      count_up <= 1'b1;
      events <= '0;
    end
    else
    begin
      timebase_count <= cnt_q;
      count_up <= dir_up_q;
      events.cmp_a <= tick && cnt_q == compare_a_active_q;
      events.cmp_b <= tick && cnt_q == compare_b_active_q;
      events.zero <= tick && ctr_zero;
      events.period <= tick && ctr_prd;
    end
  end

  // passes sync_now when sync-out select is so_sync_in: three clocks after input when tick runs every clock
  always_ff @(posedge clock)
  begin
    if (rst)
      sync_out_pulse <= 1'b0;
    else
    begin
      unique case (pwm_sync_pkg::sync_out_sel_t'(
        tb_ctl_q[pwm_sync_pkg::tbc_sync_out_lo +: 2]))
        pwm_sync_pkg::so_sync_in: sync_out_pulse <= sync_now;
        pwm_sync_pkg::so_zero: sync_out_pulse <= tick && ctr_zero;
        pwm_sync_pkg::so_cmp_b:
          sync_out_pulse <= tick && cnt_q == compare_b_active_q;
        pwm_sync_pkg::so_off: sync_out_pulse <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // read data and handshake
  logic [15:0] rd_val;
  always_comb
  begin
    unique case (idx)
      pwm_sync_pkg::idx_timebase_control: rd_val = tb_ctl_q;
      pwm_sync_pkg::idx_timebase_status:
        rd_val = {15'h0000, dir_up_q};
      pwm_sync_pkg::idx_phase_value: rd_val = phase_q;
      pwm_sync_pkg::idx_timebase_count: rd_val = cnt_q;
      pwm_sync_pkg::idx_period_value:
        rd_val = tb_ctl_q[pwm_sync_pkg::tbc_period_imm] ? prd_active_q
                                                       : prd_shadow_q;
      pwm_sync_pkg::idx_compare_control:
        rd_val = {6'h00, compare_b_full_q, compare_a_full_q, cmp_ctl_q[7:0]};
      pwm_sync_pkg::idx_compare_a_fine_extension,
      pwm_sync_pkg::idx_compare_a_fine_mirror: rd_val = compare_a_fine_q;
      pwm_sync_pkg::idx_compare_a_value,
      pwm_sync_pkg::idx_compare_a_mirror:
        rd_val = cmp_ctl_q[pwm_sync_pkg::cc_a_shadow_off] ? compare_a_active_q
                                                         : compare_a_shadow_q;
      pwm_sync_pkg::idx_compare_b_value:
        rd_val = cmp_ctl_q[pwm_sync_pkg::cc_b_shadow_off] ? compare_b_active_q
                                                         : compare_b_shadow_q;
      pwm_sync_pkg::idx_sync_source: rd_val = {14'h0000, sync_src_q};
      default: rd_val = 16'h0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      readdata <= 32'h00000000;
      waitrequest <= 1'b1;
    end
    else
    begin
      waitrequest <= !((read || write) && wait_q);
      if (read && wait_q)
        readdata <= {16'h0000, rd_val};
    end
  end

endmodule
`default_nettype wire

/* dv/pwm_sync_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module pwm_sync_asserts
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // time base
  input wire logic global_tick_align,
  input wire logic sync_out_pulse,
  input wire logic [15:0] timebase_count,
  input wire logic count_up,
  input wire pwm_sync_pkg::events_t events
);
  // ====================
  // properties
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence req_rise;
    $rose(read || write);
  endsequence
  sequence one_ack;
    !waitrequest ##1 waitrequest;
  endsequence
  sequence quiet_run;
    (!global_tick_align && !write)[*6];
  endsequence
  bus_wait_a: assert property (req_rise |=> one_ack)
    else $error("answer not after one wait cycle");
  ack_req_a: assert property (!waitrequest |-> (read || write))
    else $error("answer without request");
  reset_val_a: assert property (disable iff (1'b0) rst |=>
    (waitrequest && !sync_out_pulse && timebase_count == 16'h0000
    && count_up && events == 4'h0))
    else $error("outputs not at reset values");
  stop_hold_a: assert property (quiet_run |=>
    $stable(timebase_count) && events == 4'h0)
    else $error("counter moved while ticks stopped");
  zero_evt_a: assert property (events.zero |->
    timebase_count == 16'h0000)
    else $error("zero event with nonzero count");
  upper_zero_a: assert property (readdata[31:16] == 16'h0000)
    else $error("upper read lanes not zero");
  unmapped_read_a: assert property (read && !waitrequest
    && address[9:2] == 8'h3f |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  read_hold_a: assert property (!read |=> $stable(readdata))
    else $error("read data changed without read");
endmodule
`default_nettype wire

/* dv/sync_chain_partner.sv */
`timescale 1ns/10ps
`default_nettype none
module sync_chain_partner
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // bench command
  input wire logic fire,
  // chain wires
  input wire logic sync_out_pulse,
  output logic sync_in_pulse,
  output logic [7:0] seen
);
  // ====================
  // upstream and downstream modules
  logic pulse_q;
  logic [7:0] seen_q;
  // upstream master sends a one-clock pulse when told
  always_ff @(posedge clock)
  begin
    if (rst)
      pulse_q <= 1'b0;
    else
      pulse_q <= fire;
  end
  // downstream module counts the pulses it receives
  always_ff @(posedge clock)
  begin
    if (rst)
      seen_q <= 8'h00;
    else if (sync_out_pulse)
      seen_q <= seen_q + 8'h01;
  end
  assign sync_in_pulse = pulse_q;
  assign seen = seen_q;
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // ====================
  // signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic align = 1'b0;
  logic dca = 1'b0;
  logic dcb = 1'b0;
  logic fire = 1'b0;
  logic sync_in;
  logic sync_out;
  logic count_up;
  logic [15:0] count;
  pwm_sync_pkg::events_t events;
  logic [7:0] seen;
  logic [7:0] s0;
  logic [15:0] rd;
  logic [15:0] c1;
  int fails = 0;
  int num_checks = 0;
  int n;

  always #5 clock = ~clock;

  pwm_timebase_sync_and_compare i_pwm_timebase_sync_and_compare
  (
    .clock(clock),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .byteenable(4'hf),
    .writedata(writedata),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .sync_in_pulse(sync_in),
    .global_tick_align(align),
    .digital_compare_a_event_one(dca),
    .digital_compare_b_event_one(dcb),
    .sync_out_pulse(sync_out),
    .timebase_count(count),
    .count_up(count_up),
    .events(events)
  );

  sync_chain_partner i_sync_chain_partner
  (
    .clock(clock),
    .rst(rst),
    .fire(fire),
    .sync_out_pulse(sync_out),
    .sync_in_pulse(sync_in),
    .seen(seen)
  );

  // ====================
  // tasks
  task check(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task step(input int k);
    repeat (k) @(posedge clock);
  endtask

  task bus(input logic wr, input logic [7:0] idx, input logic [15:0] d);
    int t;
    t = 0;
    address <= {idx, 2'b00};
    writedata <= {16'h0000, d};
    write <= wr;
    read <= !wr;
    do
    begin
      @(posedge clock);
      t++;
    end
    while (waitrequest !== 1'b0 && t < 20);
    rd = readdata[15:0];
    if (t >= 20)
      fails++;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask

  task ctl(input logic [15:0] v);
    bus(1'b1, pwm_sync_pkg::idx_timebase_control, v);
  endtask

  task zero_count;
    bus(1'b1, pwm_sync_pkg::idx_timebase_count, 16'h0000);
  endtask

  // one clock of pin, compare-a and compare-b pulses
  task kick(input logic [2:0] s);
    fire <= s[0];
    dca <= s[1];
    dcb <= s[2];
    @(posedge clock);
    fire <= 1'b0;
    dca <= 1'b0;
    dcb <= 1'b0;
  endtask

  task wsync;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (sync_out !== 1'b1 && n < 12);
    // registered copies of count and direction settle one clock later
    @(posedge clock);
  endtask

  task sync_try(input logic [2:0] s, input logic [15:0] lat);
    kick(s);
    wsync();
    check("sync latency", lat, 16'(n));
    check("phase load", 16'h00c8, count);
    zero_count();
  endtask

  task wev(input int b, input logic [15:0] exp);
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (events[b] !== 1'b1 && n < 80);
    check("event count", exp, count);
  endtask

  function automatic logic [15:0] nxt(input int m, input logic [15:0] c);
    case (m)
      0: nxt = (c == 16'h001e) ? 16'h0000 : c + 16'h0001;
      1: nxt = (c == 16'h0000) ? 16'h001e : c - 16'h0001;
      default: nxt = c;
    endcase
  endfunction

  task results;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ====================
  // tests
  initial
  begin
    step(10);
    rst <= 1'b0;
    bus(1'b0, pwm_sync_pkg::idx_timebase_control, 16'h0000);
    check("control", pwm_sync_pkg::timebase_control_rst, rd);
    bus(1'b0, pwm_sync_pkg::idx_compare_control, 16'h0000);
    check("cmp control", pwm_sync_pkg::compare_control_rst, rd);
    check("direction", 16'h0001, {15'h0000, count_up});
    bus(1'b1, 8'h3f, 16'hffff);
    bus(1'b0, 8'h3f, 16'h0000);
    check("unmapped", 16'h0000, rd);
    $display("reset test done");
    ctl(16'h0008);
    bus(1'b1, pwm_sync_pkg::idx_period_value, 16'h001e);
    bus(1'b1, pwm_sync_pkg::idx_timebase_count, 16'h0007);
    step(8);
    check("stopped count", 16'h0007, count);
    align <= 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      if (m != 2)
      begin
        ctl(16'h0008 | 16'(m));
        step(3);
        c1 = count;
        step(1);
        check("mode step", nxt(m, c1), count);
      end
    end
    $display("mode test done");
    bus(1'b1, pwm_sync_pkg::idx_phase_value, 16'h00c8);
    bus(1'b1, pwm_sync_pkg::idx_sync_source, 16'h0003);
    ctl(16'h000c);
    zero_count();
    sync_try(3'b001, 16'h0004);
    sync_try(3'b010, 16'h0003);
    s0 = seen;
    sync_try(3'b110, 16'h0003);
    step(4);
    check("one pulse", {8'h00, s0 + 8'h01}, {8'h00, seen});
    s0 = seen;
    ctl(16'h004c);
    step(8);
    check("soft pulse", {8'h00, s0 + 8'h01}, {8'h00, seen});
    check("soft load", 16'h0001, {15'h0000, count >= 16'h00c8});
    zero_count();
    bus(1'b1, pwm_sync_pkg::idx_sync_source, 16'h0000);
    s0 = seen;
    kick(3'b110);
    step(8);
    check("compare off", {8'h00, s0}, {8'h00, seen});
    ctl(16'h0008);
    s0 = seen;
    kick(3'b001);
    step(8);
    check("pass on", {8'h00, s0 + 8'h01}, {8'h00, seen});
    check("no load", 16'h0001, {15'h0000, count < 16'h00c8});
    for (int d = 0; d < 3; d++)
    begin
      ctl(d == 0 ? 16'h000e : (d == 1 ? 16'h200e : 16'h000c));
      kick(3'b001);
      wsync();
      check("sync dir", d == 0 ? 16'h0000 : 16'h0001,
        {15'h0000, count_up});
      zero_count();
    end
    $display("sync test done");
    bus(1'b1, pwm_sync_pkg::idx_compare_control, 16'h0040);
    bus(1'b1, pwm_sync_pkg::idx_compare_b_value, 16'h0009);
    for (int s = 1; s < 4; s++)
    begin
      ctl(16'h0008 | 16'(s << 4));
      step(4);
      s0 = seen;
      step(62);
      check("out source", (s == 3) ? 16'h0000 : 16'h0002,
        {8'h00, seen - s0});
    end
    align <= 1'b0;
    bus(1'b1, pwm_sync_pkg::idx_compare_control, 16'h0050);
    bus(1'b1, pwm_sync_pkg::idx_compare_a_value, 16'h000a);
    bus(1'b1, pwm_sync_pkg::idx_compare_b_value, 16'h0014);
    bus(1'b1, pwm_sync_pkg::idx_compare_control, 16'h0000);
    bus(1'b1, pwm_sync_pkg::idx_compare_a_value, 16'h000c);
    bus(1'b0, pwm_sync_pkg::idx_compare_a_value, 16'h0000);
    check("shadow read", 16'h000c, rd);
    bus(1'b0, pwm_sync_pkg::idx_compare_control, 16'h0000);
    check("shadow full", 16'h0001, {15'h0000, rd[8]});
    bus(1'b1, pwm_sync_pkg::idx_timebase_count, 16'h0005);
    align <= 1'b1;
    wev(3, 16'h000a);
    wev(2, 16'h0014);
    wev(3, 16'h000c);
    wev(0, 16'h001e);
    bus(1'b0, pwm_sync_pkg::idx_compare_control, 16'h0000);
    check("full cleared", 16'h0000, {15'h0000, rd[8]});
    // b loads at period: new value must be active before count 0
    align <= 1'b0;
    bus(1'b1, pwm_sync_pkg::idx_compare_control, 16'h0004);
    bus(1'b1, pwm_sync_pkg::idx_compare_b_value, 16'h0001);
    bus(1'b1, pwm_sync_pkg::idx_timebase_count, 16'h001d);
    align <= 1'b1;
    wev(2, 16'h0001);
    $display("compare test done");
    results();
  end

  // ====================
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clock);
    fails++;
    results();
  end
endmodule

bind pwm_timebase_sync_and_compare pwm_sync_asserts i_pwm_sync_asserts
(
  .clock(clock),
  .rst(rst),
  .address(address),
  .read(read),
  .write(write),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .global_tick_align(global_tick_align),
  .sync_out_pulse(sync_out_pulse),
  .timebase_count(timebase_count),
  .count_up(count_up),
  .events(events)
);
`default_nettype wire
